// ==== rtl/rtc_cal_defines.svh ====
`ifndef RTC_CAL_DEFINES_SVH
`define RTC_CAL_DEFINES_SVH
// ****************************************
// register map
// ****************************************
`define CTRL_ADDR 15'h7FF8
`define SECS_ADDR 15'h7FF9
`define DAY_ADDR 15'h7FFC
`define CTRL_HOLD_BIT 7
`define CTRL_SLEEP_BIT 6
`define CTRL_SIGN_BIT 5
`define CTRL_MAG_MSB 4
`define SECS_HALT_BIT 7
`define DAY_BLOW_BIT 7
`define DAY_FTEN_BIT 6
`define DAY_TARM_BIT 5
`define DAY_TFLAG_BIT 4
`define REG_RESET 8'h00
// ****************************************
// divider chain, counted in oscillator cycles, stages, seconds and minutes
// ****************************************
`define OSC_HZ 32768
`define STAGE_DIV 256
`define STAGES_PER_SEC 128
`define NEG_EXTRA 128
`define POS_STAGE_STEP 2
`define SECS_PER_MIN 60
`define MINS_PER_CYCLE 64
`define CAL_SECOND 0
`define TEST_HZ 512
`define TEST_HALF_CYCLES (`OSC_HZ / (2 * `TEST_HZ))
`endif

// ==== rtl/rtc_cal_pkg.sv ====
`default_nettype none
package rtc_cal_pkg;
   typedef struct packed {
      logic hold;
      logic halt;
      logic test_en;
      logic sign;
      logic [4:0] mag;
   } cal_ctrl_t;
endpackage
`default_nettype wire

// ==== rtl/rtc_cal_divider.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cal_defines.svh"
module rtc_cal_divider
(
   input wire logic osc_clk, // oscillator clock
   input wire logic arst_n, // async reset, active low
   input wire rtc_cal_pkg::cal_ctrl_t ctrl_async, // controls from the register domain
   output logic sec_toggle, // flips once per second
   output logic test_low_oe // pull test pin low
);
   rtc_cal_pkg::cal_ctrl_t s1_r, s2_r, s3_r, q_r;
   logic [8:0] stage_r;
   logic [6:0] upper_r;
   logic [5:0] sec_r, min_r, sq_cnt_r;
   logic done_r, tog_r, sq_r, corr_on, split_now, blank_now, stage_end, sec_end, run;
   logic [7:0] up_sum;
   logic [8:0] stage_last;
   // ****************************************
   // crossing: a word is taken only once two samples agree
   // ****************************************
   always_ff @(posedge osc_clk or negedge arst_n)
      if (!arst_n)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r <= '0;
      end
      else
      begin
         s1_r <= ctrl_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            q_r <= s2_r;
      end
   // ****************************************
   // calibrated chain
   // ****************************************
   assign run = !q_r.halt;
   assign corr_on = (min_r < {q_r.mag, 1'b0}) && (sec_r == 6'(`CAL_SECOND)) && !done_r;
   assign split_now = corr_on && q_r.sign;
   assign blank_now = corr_on && !q_r.sign;
   assign stage_last = blank_now ? 9'(`STAGE_DIV + `NEG_EXTRA - 1) : 9'(`STAGE_DIV - 1);
   assign stage_end = run && (stage_r == stage_last);
   assign up_sum = {1'b0, upper_r} + (split_now ? 8'(`POS_STAGE_STEP) : 8'h01);
   assign sec_end = stage_end && (up_sum >= 8'(`STAGES_PER_SEC));
   always_ff @(posedge osc_clk or negedge arst_n)
      if (!arst_n)
      begin
         stage_r <= '0;
         upper_r <= '0;
         sec_r <= '0;
         min_r <= '0;
         done_r <= 1'b0;
         tog_r <= 1'b0;
      end
      else if (q_r.hold)
      begin
         stage_r <= '0;
         upper_r <= '0;
         sec_r <= '0;
         min_r <= '0;
         done_r <= 1'b0;
      end
      else if (run)
      begin
         stage_r <= stage_end ? 9'h000 : stage_r + 9'h001;
         if (stage_end)
         begin
            upper_r <= up_sum[6:0];
            if (corr_on)
               done_r <= 1'b1;
         end
         if (sec_end)
         begin
            tog_r <= !tog_r;
            if (sec_r == 6'(`SECS_PER_MIN - 1))
            begin
               sec_r <= '0;
               done_r <= 1'b0;
               min_r <= min_r + 6'h01;
            end
            else
               sec_r <= sec_r + 6'h01;
         end
      end
   // ****************************************
   // test output, tapped ahead of the correction
   // ****************************************
   always_ff @(posedge osc_clk or negedge arst_n)
      if (!arst_n)
      begin
         sq_cnt_r <= '0;
         sq_r <= 1'b0;
      end
      else
      begin
         if (run)
            sq_cnt_r <= sq_cnt_r + 6'h01;
         sq_r <= q_r.test_en && run && (sq_cnt_r < 6'(`TEST_HALF_CYCLES));
      end
   assign sec_toggle = tog_r;
   assign test_low_oe = sq_r;
   // ****************************************
   // checks
   // ****************************************
   logic [15:0] len_r;
   logic pos_r, neg_r;
   always_ff @(posedge osc_clk or negedge arst_n)
      if (!arst_n)
      begin
         len_r <= '0;
         pos_r <= 1'b0;
         neg_r <= 1'b0;
      end
      else if (q_r.hold || sec_end)
      begin
         len_r <= '0;
         pos_r <= 1'b0;
         neg_r <= 1'b0;
      end
      else if (run)
      begin
         len_r <= len_r + 16'h0001;
         pos_r <= pos_r | split_now;
         neg_r <= neg_r | blank_now;
      end
   default clocking @(posedge osc_clk); endclocking
   default disable iff (!arst_n);
   a_sec_len_pos: assert property (sec_end && !q_r.hold && (pos_r || split_now) |->
      len_r == 16'(`OSC_HZ - `STAGE_DIV - 1)) else $error("positive second length wrong");
   a_sec_len_neg: assert property (sec_end && !q_r.hold && neg_r |->
      len_r == 16'(`OSC_HZ + `NEG_EXTRA - 1)) else $error("negative second length wrong");
   a_sec_len_plain: assert property (sec_end && !q_r.hold && !pos_r && !neg_r && !split_now |->
      len_r <= 16'(`OSC_HZ - 1)) else $error("plain second too long");
   a_once_minute: assert property (corr_on && stage_end && !q_r.hold |=> !corr_on)
      else $error("second correction applied twice in a minute");
endmodule // rtc_cal_divider
`default_nettype wire

// ==== rtl/rtc_cal_battery_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cal_defines.svh"
module rtc_cal_battery_monitor
(
   input wire logic sys_clk, // register clock
   input wire logic arst_n, // async reset, active low
   input wire logic clk_en, // freezes register logic while low
   input wire logic osc_clk, // oscillator clock
   input wire logic [14:0] reg_addr, // register address
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [7:0] reg_wdata, // write data
   output logic [7:0] reg_rdata, // read data, registered
   input wire logic main_power_good, // main supply present, async
   input wire logic battery_below, // battery comparator, async
   input wire logic tamper_in, // tamper pin level, async
   output logic second_tick, // one-cycle pulse per second
   output logic test_pin_o, // test pin output value
   output logic test_pin_oe, // test pin drive enable
   output logic clock_write_hold, // clock-write bit
   output logic sleep_select, // sleep bit
   output logic battery_low_flag // battery-low flag
);
   // ****************************************
   // register state
   // ****************************************
   logic hold_r, sleep_r, sign_r, halt_r, ften_r, tarm_r, tflag_r, blow_r;
   logic [4:0] mag_r;
   logic [7:0] rdata_r;
   logic pg_s1_r, pg_s2_r, pg_d_r;
   logic bb_s1_r, bb_s2_r;
   logic tp_s1_r, tp_s2_r;
   logic tog_s1_r, tog_s2_r, tog_s3_r, tick_r;
   logic pwr_rise, pwr_fall, wr_ok;
   logic wr_ctrl, wr_secs, wr_day;
   logic tflag_set, tflag_clr;
   logic sec_toggle, test_low_oe;
   rtc_cal_pkg::cal_ctrl_t ctrl_out;

   // ****************************************
   // pin synchronisers
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         pg_s1_r <= 1'b0;
         pg_s2_r <= 1'b0;
         pg_d_r <= 1'b0;
      end
      else if (clk_en)
      begin
         pg_s1_r <= main_power_good;
         pg_s2_r <= pg_s1_r;
         pg_d_r <= pg_s2_r;
      end

   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         bb_s1_r <= 1'b0;
         bb_s2_r <= 1'b0;
         tp_s1_r <= 1'b0;
         tp_s2_r <= 1'b0;
      end
      else if (clk_en)
      begin
         bb_s1_r <= battery_below;
         bb_s2_r <= bb_s1_r;
         tp_s1_r <= tamper_in;
         tp_s2_r <= tp_s1_r;
      end

   // power edges seen after the synchroniser only
   assign pwr_rise = pg_s2_r && !pg_d_r;
   assign pwr_fall = !pg_s2_r && pg_d_r;

   // ****************************************
   // register decode
   // ****************************************
   // no host write is honoured while running on the battery; reads still are
   assign wr_ok = clk_en && reg_wr && pg_s2_r;
   assign wr_ctrl = wr_ok && (reg_addr == `CTRL_ADDR);
   assign wr_secs = wr_ok && (reg_addr == `SECS_ADDR);
   assign wr_day = wr_ok && (reg_addr == `DAY_ADDR);

   // ****************************************
   // control register
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         hold_r <= 1'b0;
      else if (clk_en)
      begin
         if (pwr_fall)
            hold_r <= 1'b0;
         else if (wr_ctrl)
            hold_r <= reg_wdata[`CTRL_HOLD_BIT];
      end

   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         sleep_r <= 1'b0;
         sign_r <= 1'b0;
         mag_r <= 5'h00;
      end
      else if (wr_ctrl)
      begin
         sleep_r <= reg_wdata[`CTRL_SLEEP_BIT];
         sign_r <= reg_wdata[`CTRL_SIGN_BIT];
         mag_r <= reg_wdata[`CTRL_MAG_MSB:0];
      end

   // ****************************************
   // seconds register: only the halt bit lives here
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         halt_r <= 1'b0;
      else if (wr_secs)
         halt_r <= reg_wdata[`SECS_HALT_BIT];

   // ****************************************
   // day register flags
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         ften_r <= 1'b0;
      else if (clk_en)
      begin
         if (pwr_fall)
            ften_r <= 1'b0;
         else if (wr_day)
            ften_r <= reg_wdata[`DAY_FTEN_BIT];
      end

   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         tarm_r <= 1'b0;
      else if (wr_day)
         tarm_r <= reg_wdata[`DAY_TARM_BIT];

   // a tamper event beats a simultaneous clear
   assign tflag_set = tarm_r && tp_s2_r;
   assign tflag_clr = !tarm_r && !tp_s2_r;
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         tflag_r <= 1'b0;
      else if (clk_en)
      begin
         if (tflag_set)
            tflag_r <= 1'b1;
         else if (tflag_clr)
            tflag_r <= 1'b0;
      end

   // battery level is only trusted right at a power-up; writes cannot touch it
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         blow_r <= 1'b0;
      else if (clk_en && pwr_rise)
         blow_r <= bb_s2_r;

   // ****************************************
   // read path
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
         rdata_r <= `REG_RESET;
      else if (clk_en && reg_rd)
      begin
         case (reg_addr)
            `CTRL_ADDR:
               rdata_r <= {hold_r, sleep_r, sign_r, mag_r};
            `SECS_ADDR:
               rdata_r <= {halt_r, 7'h00};
            `DAY_ADDR:
               rdata_r <= {blow_r, ften_r, tarm_r, tflag_r, 4'h0};
            default:
               rdata_r <= `REG_RESET;
         endcase
      end

   // ****************************************
   // oscillator domain
   // ****************************************
   always_comb
   begin
      ctrl_out.hold = hold_r;
      ctrl_out.halt = halt_r;
      ctrl_out.test_en = ften_r;
      ctrl_out.sign = sign_r;
      ctrl_out.mag = mag_r;
   end

   rtc_cal_divider u_divider
   (
      .osc_clk(osc_clk),
      .arst_n(arst_n),
      .ctrl_async(ctrl_out),
      .sec_toggle(sec_toggle),
      .test_low_oe(test_low_oe)
   );

   // ****************************************
   // second event back into the register domain
   // ****************************************
   always_ff @(posedge sys_clk or negedge arst_n)
      if (!arst_n)
      begin
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         tog_s3_r <= 1'b0;
         tick_r <= 1'b0;
      end
      else if (clk_en)
      begin
         tog_s1_r <= sec_toggle;
         tog_s2_r <= tog_s1_r;
         tog_s3_r <= tog_s2_r;
         tick_r <= tog_s2_r ^ tog_s3_r;
      end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata = rdata_r;
   assign second_tick = tick_r;
   // high level comes from the board pull-up
   assign test_pin_o = 1'b0;
   assign test_pin_oe = test_low_oe;
   assign clock_write_hold = hold_r;
   assign sleep_select = sleep_r;
   assign battery_low_flag = blow_r;

   // ****************************************
   // checks
   // ****************************************
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);

   sequence s_ctrl_write;
      wr_ctrl ##1 1'b1;
   endsequence

   sequence s_power_up;
      clk_en && pwr_rise ##1 1'b1;
   endsequence

   a_cal_mag_store: assert property (s_ctrl_write |-> mag_r == $past(reg_wdata[4:0]))
      else $error("calibration magnitude not stored");

   a_cal_sign_store: assert property (s_ctrl_write |-> sign_r == $past(reg_wdata[5]))
      else $error("calibration sign not stored");

   a_hold_write: assert property (wr_ctrl && !pwr_fall |=> hold_r == $past(reg_wdata[7]))
      else $error("clock-write bit not stored");

   a_halt_store: assert property (wr_secs |=> halt_r == $past(reg_wdata[7]))
      else $error("halt bit not stored");

   a_blow_sample: assert property (s_power_up |-> blow_r == $past(bb_s2_r))
      else $error("battery-low not sampled at power-up");

   a_blow_readonly: assert property (wr_day && !pwr_rise |=> $stable(blow_r))
      else $error("host write changed battery-low");

   a_blow_backup: assert property (!pg_s2_r ##1 !pg_s2_r |-> $stable(blow_r))
      else $error("battery-low changed on backup");

   a_blow_keep: assert property (!(clk_en && pwr_rise) |=> $stable(blow_r))
      else $error("battery-low changed without power-up");

   a_down_clear: assert property (clk_en && pwr_fall |=> !ften_r && !hold_r)
      else $error("power-down did not clear control bits");

   a_down_keep: assert property (clk_en && pwr_fall |=> $stable(tarm_r) && $stable(halt_r)
      && $stable(sleep_r))
      else $error("power-down disturbed kept bits");

   a_ctrl_read: assert property (clk_en && reg_rd && reg_addr == `CTRL_ADDR |=>
      reg_rdata == $past({hold_r, sleep_r, sign_r, mag_r}))
      else $error("control readback wrong");

   a_test_halted: assert property (halt_r ##1 halt_r [*7] |-> !test_pin_oe)
      else $error("test pin driven while halted");

   sequence s_day_read;
      clk_en && reg_rd && reg_addr == `DAY_ADDR ##1 1'b1;
   endsequence

   a_day_read: assert property (s_day_read |->
      reg_rdata == $past({blow_r, ften_r, tarm_r, tflag_r, 4'h0}))
      else $error("day readback wrong");

   a_secs_read: assert property (clk_en && reg_rd && reg_addr == `SECS_ADDR |=>
      reg_rdata == $past({halt_r, 7'h00}))
      else $error("seconds readback wrong");

   a_unmapped_read: assert property (clk_en && reg_rd && reg_addr != `CTRL_ADDR &&
      reg_addr != `SECS_ADDR && reg_addr != `DAY_ADDR |=> reg_rdata == `REG_RESET)
      else $error("unmapped read not zero");

   a_ften_store: assert property (wr_day && !pwr_fall |=> ften_r == $past(reg_wdata[6]))
      else $error("test enable not stored");

   a_tarm_store: assert property (wr_day |=> tarm_r == $past(reg_wdata[5]))
      else $error("tamper arm not stored");

   a_tamper_set: assert property (clk_en && tflag_set |=> tflag_r)
      else $error("tamper flag not set");

   a_write_refused: assert property (reg_wr && !pg_s2_r && !pwr_fall |=>
      $stable({hold_r, sleep_r, sign_r, mag_r, halt_r, ften_r, tarm_r}))
      else $error("write taken without main power");

   a_frozen_state: assert property (!clk_en |=> $stable({hold_r, sleep_r, sign_r, mag_r,
      halt_r, ften_r, tarm_r, tflag_r, blow_r, rdata_r, tick_r}))
      else $error("state moved while enable low");

   a_tick_pulse: assert property (clk_en && second_tick |=> !second_tick)
      else $error("second tick longer than one cycle");
endmodule // rtc_cal_battery_monitor
`default_nettype wire

// ==== testbench/rtc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host side of the register port
// ****************************************
module rtc_host_model
(
   input wire logic sys_clk, // register clock
   output logic [14:0] reg_addr, // register address
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   output logic [7:0] reg_wdata, // write data
   input wire logic [7:0] reg_rdata // read data
);
   initial
   begin
      reg_addr = 15'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // strobe set after a falling edge, taken at the rising edge, dropped at the next fall
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      // released data must not look like a held value
      reg_wdata = ~d;
   endtask

   // data registered one edge after the read edge, so sample a full cycle later
   task automatic rd(input logic [14:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask
endmodule // rtc_host_model
`default_nettype wire

// ==== testbench/rtc_cal_battery_monitor_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "rtc_cal_defines.svh"
module rtc_cal_battery_monitor_test;
   logic sys_clk, osc_clk, arst_n, clk_en, main_power_good, battery_below, tamper_in;
   wire logic [14:0] reg_addr;
   wire logic reg_wr, reg_rd, second_tick, test_pin_o, test_pin_oe;
   wire logic clock_write_hold, sleep_select, battery_low_flag;
   wire logic [7:0] reg_wdata, reg_rdata;
   int bad_count = 0;
   int n_checks = 0;
   int osc_cnt = 0;
   int tick_at = -1;
   int n;
   logic [7:0] rv;
   // pin level as seen with the external pull-up
   wire logic test_pin = test_pin_oe ? test_pin_o : 1'b1;

   rtc_cal_battery_monitor i_rtc_cal_battery_monitor (.sys_clk(sys_clk), .arst_n(arst_n),
      .clk_en(clk_en), .osc_clk(osc_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .main_power_good(main_power_good), .battery_below(battery_below),
      .tamper_in(tamper_in), .second_tick(second_tick), .test_pin_o(test_pin_o),
      .test_pin_oe(test_pin_oe), .clock_write_hold(clock_write_hold),
      .sleep_select(sleep_select), .battery_low_flag(battery_low_flag));

   rtc_host_model i_rtc_host_model (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   // ****************************************
   // clocks and timestamps
   // ****************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // phase offset keeps the two domains unrelated
   initial
   begin
      osc_clk = 1'b0;
      #3.7;
      forever #7.5 osc_clk = ~osc_clk;
   end

   always @(posedge osc_clk) osc_cnt <= osc_cnt + 1;

   // looked at on the falling edge, away from the edge that launches the pulse
   always @(negedge sys_clk)
   begin
      if (second_tick === 1'b1 && tick_at < 0)
         tick_at <= osc_cnt;
   end

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask

   task automatic rchk(input string what, input logic [14:0] a, input logic [7:0] exp);
      logic [7:0] d;
      i_rtc_host_model.rd(a, d);
      chk(what, {8'h00, exp}, {8'h00, d});
   endtask

   task automatic ticks(input int k);
      repeat (k) @(negedge sys_clk);
   endtask

   // period of the test pin in oscillator cycles, rising to rising
   task automatic pin_period(output int p);
      int start;
      logic last;
      p = 0;
      start = -1;
      last = test_pin;
      repeat (300)
      begin
         @(negedge osc_clk);
         if (test_pin === 1'b1 && last === 1'b0)
         begin
            if (start < 0)
               start = osc_cnt;
            else if (p == 0)
               p = osc_cnt - start;
         end
         last = test_pin;
      end
   endtask

   task automatic pin_changes(output int c);
      logic last;
      c = 0;
      last = test_pin;
      repeat (200)
      begin
         @(negedge osc_clk);
         if (test_pin !== last)
            c++;
         last = test_pin;
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (90000) @(posedge sys_clk);
      bad_count++;
      $display("watchdog expired");
      final_report;
   end

   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      main_power_good = 1'b0;
      battery_below = 1'b1;
      tamper_in = 1'b0;
      ticks(3);
      arst_n = 1'b1;
      ticks(2);
      main_power_good = 1'b1;
      ticks(10);
      chk("battery low after power-up", 16'h0001, {15'h0000, battery_low_flag});
      rchk("day after power-up", `DAY_ADDR, 8'h80);
      rchk("control reset", `CTRL_ADDR, 8'h00);
      rchk("seconds reset", `SECS_ADDR, 8'h00);
      i_rtc_host_model.wr(`CTRL_ADDR, 8'hA5);
      rchk("control readback", `CTRL_ADDR, 8'hA5);
      chk("clock write port", 16'h0001, {15'h0000, clock_write_hold});
      i_rtc_host_model.wr(`DAY_ADDR, 8'h00);
      rchk("battery low read only", `DAY_ADDR, 8'h80);
      rchk("unmapped read", 15'h7FF0, 8'h00);
      // a strobe while the enable is low must be ignored
      clk_en = 1'b0;
      i_rtc_host_model.wr(`CTRL_ADDR, 8'h00);
      clk_en = 1'b1;
      rchk("write while frozen", `CTRL_ADDR, 8'hA5);
      tamper_in = 1'b1;
      i_rtc_host_model.wr(`DAY_ADDR, 8'h20);
      ticks(5);
      rchk("tamper set", `DAY_ADDR, 8'hB0);
      tamper_in = 1'b0;
      i_rtc_host_model.wr(`DAY_ADDR, 8'h00);
      ticks(5);
      rchk("tamper clear", `DAY_ADDR, 8'h80);
      $display("test registers done");

      i_rtc_host_model.wr(`CTRL_ADDR, 8'h00);
      i_rtc_host_model.wr(`DAY_ADDR, 8'h40);
      ticks(20);
      pin_period(n);
      chk("test pin period", 16'h0040, 16'(n));
      chk("test pin drive value", 16'h0000, {15'h0000, test_pin_o});
      // restart under full negative trim so the lengthened stage falls in the window
      i_rtc_host_model.wr(`CTRL_ADDR, 8'h9F);
      ticks(10);
      i_rtc_host_model.wr(`CTRL_ADDR, 8'h1F);
      ticks(20);
      pin_period(n);
      chk("test pin period with trim", 16'h0040, 16'(n));
      i_rtc_host_model.wr(`SECS_ADDR, 8'h80);
      ticks(20);
      pin_changes(n);
      chk("test pin halted", 16'h0000, 16'(n));
      i_rtc_host_model.wr(`SECS_ADDR, 8'h00);
      $display("test frequency output done");

      i_rtc_host_model.wr(`CTRL_ADDR, 8'hC5);
      main_power_good = 1'b0;
      ticks(10);
      // refused on backup: hold stays clear and the control byte stays 45
      i_rtc_host_model.wr(`CTRL_ADDR, 8'h80);
      chk("clock write after power down", 16'h0000, {15'h0000, clock_write_hold});
      chk("sleep kept", 16'h0001, {15'h0000, sleep_select});
      battery_below = 1'b0;
      ticks(10);
      chk("battery low on backup", 16'h0001, {15'h0000, battery_low_flag});
      main_power_good = 1'b1;
      ticks(10);
      rchk("day after power cycle", `DAY_ADDR, 8'h00);
      chk("battery low cleared", 16'h0000, {15'h0000, battery_low_flag});
      rchk("control after power cycle", `CTRL_ADDR, 8'h45);
      $display("test power cycle done");

      // hold restarts the chain, so the next second is second 0 of minute 0
      i_rtc_host_model.wr(`CTRL_ADDR, 8'hA1);
      ticks(20);
      i_rtc_host_model.wr(`CTRL_ADDR, 8'h21);
      n = osc_cnt;
      tick_at = -1;
      for (int i = 0; i < 60000 && tick_at < 0; i++)
         @(negedge sys_clk);
      n = tick_at - n;
      // crossing latency adds a few oscillator cycles on top of the shortened second
      chk("corrected second", 16'h7F00, (n >= 32512 && n <= 32528) ? 16'h7F00 : 16'(n));
      $display("test calibration done");
      final_report;
   end
endmodule // rtc_cal_battery_monitor_test
`default_nettype wire
